//--- dls_pkg.sv
/*
 * Shared constants for the linear sweep controller: device register map,
 * control field positions, sweep codes and host command map.
 * Assumes nothing of its surroundings; imported by every other file.
 */
`default_nettype none
package dls_pkg;
    // ----------------------------------------------------------------
    // Device register map (word index on the link)
    // ----------------------------------------------------------------
    localparam int         LINK_AW                 = 5;
    localparam logic [4:0] GLOBAL_FUNCTION_REG     = 5'h01;
    localparam logic [4:0] CHANNEL_FUNCTION_REG    = 5'h03;
    localparam logic [4:0] START_FREQUENCY_WORD    = 5'h04;
    localparam logic [4:0] START_PHASE_WORD        = 5'h05;
    localparam logic [4:0] START_AMPLITUDE_WORD    = 5'h06;
    localparam logic [4:0] SWEEP_RAMP_RATES        = 5'h07;
    localparam logic [4:0] RISING_STEP_WORD        = 5'h08;
    localparam logic [4:0] FALLING_STEP_WORD       = 5'h09;
    localparam logic [4:0] SWEEP_END_WORD          = 5'h0A;
    localparam logic [31:0] REG_RESET              = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SEL_HI       = 23;   // sweep_parameter_select
    localparam int SEL_LO       = 22;
    localparam int NO_DWELL_BIT = 15;
    localparam int SWEEP_EN_BIT = 14;
    localparam int CONT_CLR_BIT = 3;
    localparam int MOD_LVL_HI   = 9;    // global_function_reg modulation level
    localparam int MOD_LVL_LO   = 8;
    localparam int RISE_RATE_LO = 0;    // sweep_ramp_rates[7:0]
    localparam int FALL_RATE_LO = 8;    // sweep_ramp_rates[15:8]
    localparam int RATE_W       = 8;
    localparam int PHASE_W      = 14;
    localparam int AMP_W        = 10;
    localparam int WORD_W       = 32;

    typedef enum logic [1:0] {
        DLS_SEL_NONE  = 2'b00,
        DLS_SEL_AMPL  = 2'b01,
        DLS_SEL_FREQ  = 2'b10,
        DLS_SEL_PHASE = 2'b11
    } dls_sel_t;

    localparam logic [1:0] MOD_TWO_LEVEL = 2'b00;

    // ----------------------------------------------------------------
    // Host command map (plain software port)
    // ----------------------------------------------------------------
    localparam logic [3:0] HOST_PIN_LEVEL = 4'h0;
    localparam logic [3:0] HOST_CHAN_SEL  = 4'h1;
    localparam logic [3:0] HOST_LINK_ADDR = 4'h2;
    localparam logic [3:0] HOST_LINK_DATA = 4'h3;
    localparam logic [3:0] HOST_UPDATE    = 4'h4;
    localparam logic [3:0] HOST_STATUS    = 4'h5;
    localparam int         ALIGN_LO       = 4;   // chan_sel[5:4]
endpackage : dls_pkg
`default_nettype wire

//--- dls_link_if.sv
/*
 * Link between the host end and the sweep device: profile pins,
 * I/O update strobe and a one-cycle register write port.
 * Assumes both ends share clk and reset_n.
 */
`timescale 1ns/1ps
`default_nettype none
interface dls_link_if #(parameter int NUM_CH = 4) (
    input wire logic clk,
    input wire logic reset_n
);
    import dls_pkg::*;
    logic [NUM_CH-1:0]  profile;    // One pin per channel
    logic               io_update;  // One-cycle pulse
    logic               wr_en;      // One-cycle write strobe
    logic [LINK_AW-1:0] wr_addr;
    logic [NUM_CH-1:0]  wr_chan;    // Channel enables for the write
    logic [31:0]        wr_data;

    modport device (input profile, io_update, wr_en, wr_addr, wr_chan, wr_data);
    modport host   (output profile, io_update, wr_en, wr_addr, wr_chan, wr_data);
endinterface : dls_link_if
`default_nettype wire

//--- dls_device.sv
/*
 * Sweep device end: per-channel linear sweep of frequency, phase or
 * amplitude with ramp rate timers, dwell and no-dwell behaviour.
 * Assumes the link is driven from logic on clk (the sync clock); the
 * profile pins are treated as asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none
module dls_device
    import dls_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    dls_link_if.device                link,
    output logic [NUM_CH*WORD_W-1:0]  sweep_word,
    output logic [NUM_CH-1:0]         sweep_busy
);
    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
        $error("dls_device: NUM_CH must be 1 to 4");
    end

    // ----------------------------------------------------------------
    // Profile pin sampling
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] pin_s1;
    logic [NUM_CH-1:0] pin_s2;
    logic [NUM_CH-1:0] pin_s3;
    logic [NUM_CH-1:0] pin_lvl;
    logic [NUM_CH-1:0] next_pin_lvl;
    logic [NUM_CH-1:0] pin_rise;
    logic [NUM_CH-1:0] pin_fall;
    logic [31:0]       global_fn;

    // Three stages; a change counts only once the last two agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1  <= '0;
            pin_s2  <= '0;
            pin_s3  <= '0;
            pin_lvl <= '0;
        end else begin
            pin_s1  <= link.profile;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_lvl <= next_pin_lvl;
        end
    end

    // Edges from the filtered level and its previous sample
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            next_pin_lvl[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin_lvl[i];
        end
        pin_rise = next_pin_lvl & ~pin_lvl;
        pin_fall = ~next_pin_lvl & pin_lvl;
    end

    // Global modulation level is shared by all channels
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            global_fn <= REG_RESET;
        end else if (link.wr_en && link.wr_addr == GLOBAL_FUNCTION_REG) begin
            global_fn <= link.wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Per-channel sweep engines
    // ----------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [31:0]       chan_fn;
        logic [31:0]       start_f;
        logic [31:0]       start_p;
        logic [31:0]       start_a;
        logic [31:0]       rates;
        logic [31:0]       rise_w;
        logic [31:0]       fall_w;
        logic [31:0]       end_w;
        logic [31:0]       cur;
        logic [RATE_W-1:0] tmr;
        logic              armed;
        logic              busy;
        logic              hit;
        dls_sel_t          sel;
        logic [31:0]       mask;
        logic [31:0]       start_m;
        logic [31:0]       end_m;
        logic [31:0]       rise_m;
        logic [31:0]       fall_m;
        logic              active;
        logic              no_dwell;
        logic              up;
        logic              tick;
        logic [32:0]       sum_up;
        logic [32:0]       floor_dn;

        assign hit = link.wr_en && link.wr_chan[c];

        // Register writes land at once, so mid-sweep edits hit the next step
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                chan_fn <= REG_RESET;
                start_f <= REG_RESET;
                start_p <= REG_RESET;
                start_a <= REG_RESET;
                rates   <= REG_RESET;
                rise_w  <= REG_RESET;
                fall_w  <= REG_RESET;
                end_w   <= REG_RESET;
            end else if (hit) begin
                if (link.wr_addr == CHANNEL_FUNCTION_REG) begin
                    chan_fn <= link.wr_data;
                end else if (link.wr_addr == START_FREQUENCY_WORD) begin
                    start_f <= link.wr_data;
                end else if (link.wr_addr == START_PHASE_WORD) begin
                    start_p <= link.wr_data;
                end else if (link.wr_addr == START_AMPLITUDE_WORD) begin
                    start_a <= link.wr_data;
                end else if (link.wr_addr == SWEEP_RAMP_RATES) begin
                    rates   <= link.wr_data;
                end else if (link.wr_addr == RISING_STEP_WORD) begin
                    rise_w  <= link.wr_data;
                end else if (link.wr_addr == FALLING_STEP_WORD) begin
                    fall_w  <= link.wr_data;
                end else if (link.wr_addr == SWEEP_END_WORD) begin
                    end_w   <= link.wr_data;
                end
            end
        end

        // Decode of swept quantity; all math runs MSB-aligned in 32 bits
        always_comb begin
            sel      = dls_sel_t'(chan_fn[SEL_HI:SEL_LO]);
            no_dwell = chan_fn[NO_DWELL_BIT];
            active   = chan_fn[SWEEP_EN_BIT] && sel != DLS_SEL_NONE
                       && global_fn[MOD_LVL_HI:MOD_LVL_LO] == MOD_TWO_LEVEL;
            case (sel)
                DLS_SEL_AMPL: begin
                    mask    = {{AMP_W{1'b1}}, {(WORD_W-AMP_W){1'b0}}};
                    start_m = {start_a[AMP_W-1:0], {(WORD_W-AMP_W){1'b0}}};
                end
                DLS_SEL_PHASE: begin
                    mask    = {{PHASE_W{1'b1}}, {(WORD_W-PHASE_W){1'b0}}};
                    start_m = {start_p[PHASE_W-1:0], {(WORD_W-PHASE_W){1'b0}}};
                end
                default: begin
                    mask    = 32'hFFFF_FFFF;
                    start_m = start_f;
                end
            endcase
            end_m    = end_w & mask;
            rise_m   = rise_w & mask;
            fall_m   = fall_w & mask;
            // No-dwell always climbs; the falling settings never matter
            up       = no_dwell ? 1'b1 : pin_lvl[c];
            tick     = (tmr == 8'h01);
            sum_up   = {1'b0, cur} + {1'b0, rise_m};
            floor_dn = {1'b0, start_m} + {1'b0, fall_m};
        end

        // Ramp rate timer; a load of 0 wraps to give 256 periods
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                tmr <= 8'h01;
            end else if (!active) begin
                tmr <= 8'h01;
            end else if (pin_rise[c]) begin
                tmr <= rates[RISE_RATE_LO +: RATE_W];
            end else if (pin_fall[c] && !no_dwell) begin
                tmr <= rates[FALL_RATE_LO +: RATE_W];
            end else if (link.io_update) begin
                tmr <= up ? rates[RISE_RATE_LO +: RATE_W]
                          : rates[FALL_RATE_LO +: RATE_W];
            end else if (tick) begin
                tmr <= up ? rates[RISE_RATE_LO +: RATE_W]
                          : rates[FALL_RATE_LO +: RATE_W];
            end else begin
                tmr <= tmr - 8'h01;
            end
        end

        // Sweep accumulator held as the swept word itself
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                cur   <= REG_RESET;
                armed <= 1'b0;
            end else if (!active || chan_fn[CONT_CLR_BIT]) begin
                cur   <= start_m;
                armed <= 1'b0;
            end else if (no_dwell) begin
                if (pin_rise[c]) begin
                    armed <= 1'b1;
                end else if (armed && cur == end_m) begin
                    cur   <= start_m;
                    armed <= 1'b0;
                end else if (armed && tick) begin
                    cur <= (sum_up >= {1'b0, end_m}) ? end_m : sum_up[31:0];
                end
            end else if (tick && up && cur != end_m) begin
                cur <= (sum_up >= {1'b0, end_m}) ? end_m : sum_up[31:0];
            end else if (tick && !up && cur != start_m) begin
                cur <= ({1'b0, cur} <= floor_dn) ? start_m : cur - fall_m;
            end
        end

        // Dwell follows the pin level, so busy means not yet at target
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                busy <= 1'b0;
            end else begin
                busy <= active && (no_dwell ? armed : (cur != (up ? end_m : start_m)));
            end
        end

        assign sweep_word[c*WORD_W +: WORD_W] = cur;
        assign sweep_busy[c]                  = busy;
    end
endmodule : dls_device
`default_nettype wire

//--- dls_host.sv
/*
 * Host end: turns plain software register accesses into link writes,
 * I/O update pulses and profile pin levels.
 * Assumes a single-cycle software port on clk; reads answer next cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module dls_host
    import dls_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  sw_addr,
    input  wire logic [31:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [31:0]      sw_rdata,
    dls_link_if.host         link
);
    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
        $error("dls_host: NUM_CH must be 1 to 4");
    end

    // ----------------------------------------------------------------
    // Command registers
    // ----------------------------------------------------------------
    logic [5:0]         chan_sel;    // [3:0] channels, [5:4] alignment
    logic [LINK_AW-1:0] link_addr;
    logic [7:0]         wr_count;
    logic [31:0]        aligned;
    logic [31:0]        next_data;

    // Software gives the short word; the host shifts end and step words to the MSBs
    always_comb begin
        case (dls_sel_t'(chan_sel[ALIGN_LO+1:ALIGN_LO]))
            DLS_SEL_AMPL:  aligned = {sw_wdata[AMP_W-1:0], {(WORD_W-AMP_W){1'b0}}};
            DLS_SEL_PHASE: aligned = {sw_wdata[PHASE_W-1:0], {(WORD_W-PHASE_W){1'b0}}};
            default:       aligned = sw_wdata;
        endcase
        next_data = aligned;
        if (link_addr == GLOBAL_FUNCTION_REG) begin
            next_data = sw_wdata;
            next_data[MOD_LVL_HI:MOD_LVL_LO] = MOD_TWO_LEVEL;
        end else if (link_addr == SWEEP_END_WORD || link_addr == RISING_STEP_WORD
                     || link_addr == FALLING_STEP_WORD) begin
            next_data = aligned;
        end else begin
            next_data = sw_wdata;
        end
    end

    // Local settings; select and link address stay here, the level drives the profile pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_sel     <= 6'h0F;
            link_addr    <= '0;
            link.profile <= '0;
        end else if (sw_wr) begin
            if (sw_addr == HOST_PIN_LEVEL) begin
                link.profile <= sw_wdata[NUM_CH-1:0];
            end else if (sw_addr == HOST_CHAN_SEL) begin
                chan_sel <= sw_wdata[5:0];
            end else if (sw_addr == HOST_LINK_ADDR) begin
                link_addr <= sw_wdata[LINK_AW-1:0];
            end
        end
    end

    // Link write and update strobes, one cycle each
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.wr_en     <= 1'b0;
            link.wr_addr   <= '0;
            link.wr_chan   <= '0;
            link.wr_data   <= '0;
            link.io_update <= 1'b0;
            wr_count       <= 8'h00;
        end else begin
            link.wr_en     <= sw_wr && sw_addr == HOST_LINK_DATA;
            link.io_update <= sw_wr && sw_addr == HOST_UPDATE;
            if (sw_wr && sw_addr == HOST_LINK_DATA) begin
                link.wr_addr <= link_addr;
                link.wr_chan <= chan_sel[NUM_CH-1:0];
                link.wr_data <= next_data;
                wr_count     <= wr_count + 8'h01;
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_rdata <= '0;
        end else if (!sw_rd) begin
            sw_rdata <= '0;
        end else if (sw_addr == HOST_PIN_LEVEL) begin
            sw_rdata <= {{(32-NUM_CH){1'b0}}, link.profile};
        end else if (sw_addr == HOST_CHAN_SEL) begin
            sw_rdata <= {26'h0, chan_sel};
        end else if (sw_addr == HOST_LINK_ADDR) begin
            sw_rdata <= {27'h0, link_addr};
        end else if (sw_addr == HOST_LINK_DATA) begin
            sw_rdata <= link.wr_data;
        end else if (sw_addr == HOST_STATUS) begin
            sw_rdata <= {24'h0, wr_count};
        end else begin
            sw_rdata <= '0;
        end
    end
endmodule : dls_host
`default_nettype wire

//--- dls_checker.sv
/*
 * Checker for the sweep link and the channel 0 swept word.
 * Assumes it sits beside the link interface in the bench, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module dls_checker
    import dls_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input wire logic                     clk,
    input wire logic                     reset_n,
    input wire logic [NUM_CH-1:0]        profile,
    input wire logic                     io_update,
    input wire logic                     wr_en,
    input wire logic [LINK_AW-1:0]       wr_addr,
    input wire logic [NUM_CH-1:0]        wr_chan,
    input wire logic [31:0]              wr_data,
    input wire logic [NUM_CH*WORD_W-1:0] sweep_word,
    input wire logic [NUM_CH-1:0]        sweep_busy
);
    // ----------------------------------------------------------------
    // Channel 0 shadow of link writes
    // ----------------------------------------------------------------
    logic [31:0]       ch_fn, s_w, e_w, r_w, f_w, w;
    logic [3:0]        wr_age, q_age;
    logic [NUM_CH-1:0] prof_q;
    logic              fm, nd;

    // Frequency mode only, and only once recent writes have settled
    assign w  = sweep_word[31:0];
    assign fm = ch_fn[SEL_HI:SEL_LO] == DLS_SEL_FREQ && ch_fn[SWEEP_EN_BIT] && wr_age > 4'h3;
    assign nd = ch_fn[NO_DWELL_BIT];

    // Shadow registers follow channel 0 writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch_fn <= REG_RESET;
            s_w <= REG_RESET;
            e_w <= REG_RESET;
            r_w <= REG_RESET;
            f_w <= REG_RESET;
        end else if (wr_en && wr_chan[0]) begin
            case (wr_addr)
                CHANNEL_FUNCTION_REG: ch_fn <= wr_data;
                START_FREQUENCY_WORD: s_w <= wr_data;
                SWEEP_END_WORD:       e_w <= wr_data;
                RISING_STEP_WORD:     r_w <= wr_data;
                FALLING_STEP_WORD:    f_w <= wr_data;
                default: ;
            endcase
        end
    end

    // Quiet-time counters; saturate so long idle spans stay cheap
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_age <= 4'h0;
            q_age  <= 4'h0;
            prof_q <= '0;
        end else begin
            prof_q <= profile;
            wr_age <= wr_en ? 4'h0 : (wr_age == 4'hF ? wr_age : wr_age + 4'h1);
            q_age  <= (wr_en || profile != prof_q) ? 4'h0 :
                      (q_age == 4'hF ? q_age : q_age + 4'h1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_MOD_TWO_LEVEL: assert property (wr_en && wr_addr == GLOBAL_FUNCTION_REG
        |-> wr_data[MOD_LVL_HI:MOD_LVL_LO] == MOD_TWO_LEVEL) else $error("level not two");
    AST_RISE_STEP: assert property (fm && w > $past(w)
        |-> w == $past(w) + r_w || w == e_w) else $error("bad rising step");
    AST_FALL_STEP: assert property (fm && !nd && w < $past(w)
        |-> w == $past(w) - f_w || w == s_w) else $error("bad falling step");
    AST_NODWELL_REVERT: assert property (fm && nd && w == e_w && e_w != s_w && !wr_en
        |=> w == s_w) else $error("no revert to start");
    AST_NODWELL_NO_FALL: assert property (fm && nd && w < $past(w)
        |-> w == s_w) else $error("falling step in no-dwell");
    AST_SETTLED_HOLD: assert property (q_age == 4'hF && !sweep_busy[0]
        |=> $stable(w)) else $error("word moved while idle");
    AST_CLEAR_HOLDS: assert property (fm && ch_fn[CONT_CLR_BIT]
        |-> w == s_w) else $error("clear not holding");
    AST_PIN_SYNC: assert property ($rose(profile[0]) && !sweep_busy[0] && wr_age > 4'h3
        |=> $stable(w) [*2]) else $error("pin acted unsynchronised");
endmodule : dls_checker
`default_nettype wire

//--- dls_linear_sweep_control_tb.sv
/*
 * Bench joining host and device ends over the link; software port tests.
 * Assumes the designer's host map and one 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dls_linear_sweep_control_tb
    import dls_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals, instances, tasks
    // ----------------------------------------------------------------
    localparam logic [31:0] SWEEP_START_POINT = 32'h0000_1000;
    localparam logic [31:0] SWEEP_END_POINT   = SWEEP_START_POINT + 32'h0000_0100;
    localparam dls_sel_t    SEL [3] = '{DLS_SEL_PHASE, DLS_SEL_AMPL, DLS_SEL_NONE};
    localparam logic [4:0]  SA [3] = '{START_PHASE_WORD, START_AMPLITUDE_WORD, 5'h04};
    localparam logic [1:0]  AL [3] = '{2'b11, 2'b01, 2'b00};
    localparam int          SH [3] = '{WORD_W - PHASE_W, WORD_W - AMP_W, 0};
    localparam logic [31:0] SD [3] = '{32'h10, 32'h4, 32'h55};   // Nonzero so a held start shows
    localparam logic [31:0] ED [3] = '{32'h30, 32'hC, 32'h99};
    logic         clk      = 1'b0;
    logic         reset_n  = 1'b0;
    logic [3:0]   sw_addr  = 4'h0;
    logic [31:0]  sw_wdata = 32'h0;
    logic         sw_wr    = 1'b0;
    logic         sw_rd    = 1'b0;
    logic [31:0]  sw_rdata, d, ee;
    logic [127:0] sweep_word;
    logic [3:0]   sweep_busy;
    logic [3:0]   pins     = 4'h0;
    int           failures = 0, total_checks = 0, cycles = 0, n;

    // Free-running clock
    always #5 clk = ~clk;

    dls_link_if #(.NUM_CH(4)) i_dls_link_if (.clk(clk), .reset_n(reset_n));
    dls_host #(.NUM_CH(4)) i_dls_host (.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .link(i_dls_link_if.host));
    dls_device #(.NUM_CH(4)) i_dls_device (.clk(clk), .reset_n(reset_n),
        .link(i_dls_link_if.device), .sweep_word(sweep_word), .sweep_busy(sweep_busy));
    dls_checker #(.NUM_CH(4)) i_dls_checker (.clk(clk), .reset_n(reset_n),
        .profile(i_dls_link_if.profile), .io_update(i_dls_link_if.io_update),
        .wr_en(i_dls_link_if.wr_en), .wr_addr(i_dls_link_if.wr_addr),
        .wr_chan(i_dls_link_if.wr_chan), .wr_data(i_dls_link_if.wr_data),
        .sweep_word(sweep_word), .sweep_busy(sweep_busy));

    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            $display("FAIL at %0t: timeout", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        sw_addr <= a; sw_wdata <= v; sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        sw_addr <= a; sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(negedge clk);
        v = sw_rdata;
    endtask : rd

    task automatic lw(input logic [4:0] a, input logic [31:0] v);
        wr(HOST_LINK_ADDR, {27'h0, a});
        wr(HOST_LINK_DATA, v);
    endtask : lw

    task automatic pin(input int c, input logic v);
        pins[c] = v;
        wr(HOST_PIN_LEVEL, {28'h0, pins});
    endtask : pin

    function automatic logic [31:0] wd(input int c);
        return sweep_word[c*32 +: 32];
    endfunction : wd

    function automatic logic [31:0] fnw(input dls_sel_t s, input logic nd, input logic cl);
        return (32'(s) << SEL_LO) | (32'h1 << SWEEP_EN_BIT) | (32'(nd) << NO_DWELL_BIT)
            | (32'(cl) << CONT_CLR_BIT);
    endfunction : fnw

    // Cycles until the word changes; counted between falling edges
    task automatic wc(input int c, output int k);
        logic [31:0] o;
        o = wd(c);
        k = 0;
        do begin @(negedge clk); k++; end while (wd(c) === o && k < 400);
    endtask : wc

    task automatic wv(input int c, input logic [31:0] v, input int mx);
        int k;
        k = 0;
        while (wd(c) !== v && k < mx) begin @(negedge clk); k++; end
    endtask : wv

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rd(HOST_STATUS, d); chk(d, 32'h0);
        rd(4'hF, d); chk(d, 32'h0);
        wr(HOST_CHAN_SEL, 32'h1); rd(HOST_CHAN_SEL, d); chk(d, 32'h1);
        lw(GLOBAL_FUNCTION_REG, 32'h0000_0300);
        rd(HOST_LINK_DATA, d); chk(d, 32'h0);
        rd(HOST_STATUS, d); chk(d, 32'h1);
        $display("test host port done");
        lw(START_FREQUENCY_WORD, SWEEP_START_POINT); lw(SWEEP_END_WORD, SWEEP_END_POINT);
        lw(RISING_STEP_WORD, 32'h10); lw(FALLING_STEP_WORD, 32'h20);
        lw(SWEEP_RAMP_RATES, 32'h0503); lw(CHANNEL_FUNCTION_REG, fnw(DLS_SEL_FREQ, 0, 0));
        wv(0, SWEEP_START_POINT, 20); chk(wd(0), SWEEP_START_POINT);
        pin(0, 1); wc(0, n); wc(0, n); chk(n, 3);
        chk(wd(0), SWEEP_START_POINT + 32'h20);
        chk({31'h0, sweep_busy[0]}, 32'h1);
        lw(SWEEP_RAMP_RATES, 32'h0506); wc(0, n); wc(0, n); chk(n, 6);
        // Update lands mid-interval, away from a tick, so the next step slips
        wc(0, n); @(negedge clk); wr(HOST_UPDATE, 32'h0);
        wc(0, n); chk(n, 8);
        wv(0, SWEEP_END_POINT, 200); repeat (20) @(negedge clk);
        chk(wd(0), SWEEP_END_POINT);
        chk({31'h0, sweep_busy[0]}, 32'h0);
        pin(0, 0); wc(0, n); wc(0, n); chk(n, 5);
        wv(0, SWEEP_START_POINT, 200); chk(wd(0), SWEEP_START_POINT);
        $display("test dwell sweep done");
        lw(SWEEP_RAMP_RATES, 32'h0000); pin(0, 1); wc(0, n); wc(0, n); chk(n, 256);
        lw(CHANNEL_FUNCTION_REG, fnw(DLS_SEL_FREQ, 0, 1)); repeat (5) @(negedge clk);
        chk(wd(0), SWEEP_START_POINT);
        repeat (300) @(negedge clk); chk(wd(0), SWEEP_START_POINT);
        lw(CHANNEL_FUNCTION_REG, fnw(DLS_SEL_FREQ, 0, 0)); wc(0, n); chk(32'(n < 400), 1);
        $display("test slow rate and clear done");
        lw(SWEEP_RAMP_RATES, 32'h0508); lw(CHANNEL_FUNCTION_REG, fnw(DLS_SEL_FREQ, 1, 0));
        pin(0, 0); repeat (10) @(negedge clk); pin(0, 1); wc(0, n); pin(0, 0);
        wv(0, SWEEP_END_POINT, 400); chk(wd(0), SWEEP_END_POINT);
        @(negedge clk); chk(wd(0), SWEEP_START_POINT);
        repeat (20) @(negedge clk); chk(wd(0), SWEEP_START_POINT);
        $display("test no-dwell done");
        for (int i = 0; i < 3; i++) begin
            wr(HOST_CHAN_SEL, (32'h1 << (i + 1)) | (32'(AL[i]) << ALIGN_LO));
            lw(SA[i], SD[i]); lw(SWEEP_END_WORD, ED[i]); lw(RISING_STEP_WORD, SD[i]);
            lw(SWEEP_RAMP_RATES, 32'h0101); lw(CHANNEL_FUNCTION_REG, fnw(SEL[i], 0, 0));
            wv(i + 1, SD[i] << SH[i], 20); chk(wd(i + 1), SD[i] << SH[i]);
            ee = (SEL[i] == DLS_SEL_NONE) ? (SD[i] << SH[i]) : (ED[i] << SH[i]);
            pin(i + 1, 1); wv(i + 1, ee, 60); chk(wd(i + 1), ee);
        end
        chk(wd(0), SWEEP_START_POINT);
        $display("test channel table done");
        end_sim();
    end
endmodule : dls_linear_sweep_control_tb
`default_nettype wire
